// *** fpc_regs.svh ***
// constants for the coprocessor fetch and operand sequencer
`ifndef FPC_REGS_SVH
`define FPC_REGS_SVH
// word bit n sits at index 17-n
`define FPC_OPC_HI 17
`define FPC_OPC_LO 12
`define FPC_OPC_VAL 6'o71
`define FPC_NOP_WORD 18'o710000
`define FPC_IND_BIT 17
`define FPC_NOFETCH_BIT 7
`define FPC_FMT_HI 6
`define FPC_FMT_LO 5
`define FPC_FUNC_HI 4
`define FPC_FUNC_LO 0
`define FPC_FN_ADD 5'h01
`define FPC_FN_SUB 5'h02
`define FPC_FN_RSUB 5'h03
`define FPC_FN_RDIV 5'h04
`define FPC_FN_FIX 5'h05
`define FPC_A_CTRL 8'h00
`define FPC_A_STATUS 8'h04
`define FPC_A_INSTR 8'h08
`define FPC_A_ADDR 8'h0C
`define FPC_A_EXPO 8'h10
`define FPC_A_ACC_LO 8'h14
`define FPC_A_ACC_HI 8'h18
`define FPC_A_QUOT 8'h1C
`define FPC_A_OPB 8'h20
`define FPC_CTRL_RST 1'b1
`define FPC_TS_LAST 2'h3
`endif

// *** fpc_pkg.sv ***
// types of the coprocessor fetch and operand sequencer
package fpc_pkg;
	typedef enum logic [3:0] {
		FPC_IDLE, FPC_ADDR_RST, FPC_ADDR_RDA, FPC_SUBST, FPC_SUBST_ACK, FPC_LOAD_ADDR, FPC_IO_WAIT,
		FPC_MREQ, FPC_MDROP, FPC_MRST, FPC_MDACK, FPC_WORD, FPC_ALIGN
	} fpc_state_type;
	typedef enum logic [1:0] {FPC_K_EXPO, FPC_K_HI, FPC_K_LO, FPC_K_SLO} fpc_kind_type;
endpackage

// *** fpc_mant.sv ***
// mantissa registers: accumulator, quotient and operand b
`timescale 1ns/1ps
`default_nettype none
module fpc_mant #(
	parameter int MW = 36
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clr_quot,
	input wire logic acc_to_quot,
	input wire logic acc_to_opb,
	input wire logic load_acc,
	input wire logic [MW-1:0] acc_in,
	output logic [MW-1:0] acc,
	output logic [MW-1:0] quot,
	output logic [MW-1:0] opb
);
	logic [MW-1:0] acc_ff;
	logic [MW-1:0] quot_ff;
	logic [MW-1:0] opb_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_ff <= '0;
			quot_ff <= '0;
			opb_ff <= '0;
		end else begin
			if (load_acc) begin
				acc_ff <= acc_in;
			end
			if (clr_quot) begin
				quot_ff <= '0;
			end else if (acc_to_quot) begin
				quot_ff <= acc_ff;
			end
			if (acc_to_opb) begin
				opb_ff <= acc_ff;
			end
		end
	end

	assign acc = acc_ff;
	assign quot = quot_ff;
	assign opb = opb_ff;

	AST_QUOT_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
		clr_quot |=> quot_ff == '0) else $error("quotient not cleared");
	AST_OPB_COPY: assert property (@(posedge pclk) disable iff (!presetn)
		acc_to_opb |=> opb_ff == $past(acc_ff)) else $error("operand b not loaded from accumulator");
endmodule
`default_nettype wire

// *** fpc_seq.sv ***
// fetch and operand sequencer of the floating-point coprocessor
`timescale 1ns/1ps
`default_nettype none
`include "fpc_regs.svh"
module fpc_seq (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [17:0] memory_data_lines_in,
	output logic [17:0] memory_data_lines_out,
	output logic memory_data_lines_oe,
	input wire logic cpu_instruction_fetch_flag,
	input wire logic read_restart,
	input wire logic address_ack,
	input wire logic release_acknowledge,
	input wire logic memory_release,
	input wire logic io_request_pending,
	input wire logic align_done,
	output logic memory_request,
	output logic memory_read_select,
	output logic unit_release_data_ack,
	output logic substitute_read_restart,
	output logic cpu_release_ack,
	output logic busy,
	output logic cpu_activity_inhibit,
	output logic read_restart_inhibit,
	output logic priority_interrupt_disable,
	output logic vectored_priority_interrupt_disable,
	output logic characteristic_align_cycle
);
	fpc_pkg::fpc_state_type state_ff, nxt_state;
	logic [35:0] memory_buffer_register_ff;
	logic [35:0] nxt_buf;
	logic [17:0] instruction_register_ff;
	logic [17:0] address_register_ff;
	logic [17:0] nxt_address_register;
	logic [17:0] exponent_register_a_ff;
	logic [17:0] lines_out_ff;
	logic lines_oe_ff;
	logic busy_ff;
	logic cpu_inhibit_ff;
	logic rri_ff;
	logic ind_ff;
	logic fetch_cyc_ff;
	logic [1:0] idx_ff;
	logic [1:0] ts_ff;
	logic ctrl_en_ff;
	logic [31:0] prdata_ff;
	logic [35:0] acc;
	logic [35:0] quot;
	logic [35:0] opb;

	// decode
	wire opc_hit = memory_data_lines_in[`FPC_OPC_HI:`FPC_OPC_LO] == `FPC_OPC_VAL;
	wire detect = ctrl_en_ff && (state_ff == fpc_pkg::FPC_IDLE) && cpu_instruction_fetch_flag && opc_hit;
	wire [1:0] fmt = instruction_register_ff[`FPC_FMT_HI:`FPC_FMT_LO];
	wire [4:0] func = instruction_register_ff[`FPC_FUNC_HI:`FPC_FUNC_LO];
	wire no_fetch = instruction_register_ff[`FPC_NOFETCH_BIT];
	wire io_free = !io_request_pending;
	// word count and last index per format
	wire [1:0] last_idx = (fmt == 2'b11) ? 2'h2 : (fmt == 2'b00) ? 2'h0 : 2'h1;
	wire last_word = idx_ff == last_idx;
	wire in_mreq = state_ff == fpc_pkg::FPC_MREQ;
	wire in_subst = state_ff == fpc_pkg::FPC_SUBST;
	wire ts_two = fetch_cyc_ff && ts_ff == 2'h2;
	wire ts_three = fetch_cyc_ff && ts_ff == `FPC_TS_LAST;
	wire clr_quot = ts_three && (func == `FPC_FN_ADD || func == `FPC_FN_SUB || func == `FPC_FN_FIX);
	wire acc_to_quot = ts_two && func == `FPC_FN_RDIV;
	wire acc_to_opb = ts_two && func == `FPC_FN_RSUB;
	wire load_acc = (state_ff == fpc_pkg::FPC_WORD) && !ind_ff && last_word;

	// which half of the buffer a word lands in
	function automatic fpc_pkg::fpc_kind_type word_kind(input logic [1:0] f, input logic [1:0] i);
		fpc_pkg::fpc_kind_type k;
		k = fpc_pkg::FPC_K_LO;
		case (f)
			2'b11: k = (i == 2'h0) ? fpc_pkg::FPC_K_EXPO : (i == 2'h1) ? fpc_pkg::FPC_K_HI : fpc_pkg::FPC_K_LO;
			2'b01: k = (i == 2'h0) ? fpc_pkg::FPC_K_EXPO : fpc_pkg::FPC_K_HI;
			2'b10: k = (i == 2'h0) ? fpc_pkg::FPC_K_HI : fpc_pkg::FPC_K_LO;
			default: k = fpc_pkg::FPC_K_SLO;
		endcase
		return k;
	endfunction

	wire fpc_pkg::fpc_kind_type kind = word_kind(fmt, idx_ff);

	// next state
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			fpc_pkg::FPC_IDLE: begin
				if (detect) begin
					nxt_state = fpc_pkg::FPC_ADDR_RST;
				end
			end
			fpc_pkg::FPC_ADDR_RST: begin
				if (read_restart) begin
					nxt_state = fpc_pkg::FPC_ADDR_RDA;
				end
			end
			fpc_pkg::FPC_ADDR_RDA: begin
				if (release_acknowledge) begin
					nxt_state = fpc_pkg::FPC_SUBST;
				end
			end
			fpc_pkg::FPC_SUBST: begin
				if (memory_release) begin
					nxt_state = fpc_pkg::FPC_SUBST_ACK;
				end
			end
			fpc_pkg::FPC_SUBST_ACK: begin
				if (!memory_release) begin
					nxt_state = fpc_pkg::FPC_LOAD_ADDR;
				end
			end
			fpc_pkg::FPC_LOAD_ADDR: begin
				nxt_state = fpc_pkg::FPC_IO_WAIT;
			end
			fpc_pkg::FPC_IO_WAIT: begin
				if (io_free) begin
					if (ind_ff || !no_fetch) begin
						nxt_state = fpc_pkg::FPC_MREQ;
					end else begin
						nxt_state = fpc_pkg::FPC_ALIGN;
					end
				end
			end
			fpc_pkg::FPC_MREQ: begin
				if (address_ack) begin
					nxt_state = fpc_pkg::FPC_MDROP;
				end
			end
			fpc_pkg::FPC_MDROP: begin
				if (!address_ack) begin
					nxt_state = fpc_pkg::FPC_MRST;
				end
			end
			fpc_pkg::FPC_MRST: begin
				if (read_restart) begin
					nxt_state = fpc_pkg::FPC_MDACK;
				end
			end
			fpc_pkg::FPC_MDACK: begin
				if (release_acknowledge) begin
					nxt_state = fpc_pkg::FPC_WORD;
				end
			end
			fpc_pkg::FPC_WORD: begin
				if (ind_ff) begin
					nxt_state = fpc_pkg::FPC_IO_WAIT;
				end else if (last_word) begin
					nxt_state = fpc_pkg::FPC_ALIGN;
				end else begin
					nxt_state = fpc_pkg::FPC_MREQ;
				end
			end
			fpc_pkg::FPC_ALIGN: begin
				if (align_done) begin
					nxt_state = fpc_pkg::FPC_IDLE;
				end
			end
			default: nxt_state = fpc_pkg::FPC_IDLE;
		endcase
	end

	// buffer capture
	always_comb begin
		nxt_buf = memory_buffer_register_ff;
		if (detect) begin
			nxt_buf[17:0] = memory_data_lines_in;
		end else if ((state_ff == fpc_pkg::FPC_ADDR_RST) && read_restart) begin
			nxt_buf[17:0] = memory_data_lines_in;
		end else if ((state_ff == fpc_pkg::FPC_MRST) && read_restart) begin
			if (ind_ff) begin
				nxt_buf[17:0] = memory_data_lines_in;
			end else begin
				case (kind)
					fpc_pkg::FPC_K_HI: nxt_buf[35:18] = memory_data_lines_in;
					fpc_pkg::FPC_K_SLO: nxt_buf = {{18{memory_data_lines_in[17]}}, memory_data_lines_in};
					default: nxt_buf[17:0] = memory_data_lines_in;
				endcase
			end
		end else if ((state_ff == fpc_pkg::FPC_WORD) && !ind_ff && kind == fpc_pkg::FPC_K_EXPO) begin
			// single float clears the low nine bits, 8:0, of the first word in the buffer
			nxt_buf[8:0] = (fmt == 2'b01) ? 9'h000 : memory_buffer_register_ff[8:0];
		end
	end

	// address register
	always_comb begin
		nxt_address_register = address_register_ff;
		if (state_ff == fpc_pkg::FPC_LOAD_ADDR) begin
			nxt_address_register = memory_buffer_register_ff[17:0];
		end else if (state_ff == fpc_pkg::FPC_WORD) begin
			if (ind_ff) begin
				nxt_address_register = memory_buffer_register_ff[17:0];
			end else begin
				nxt_address_register = 18'(address_register_ff + 18'h00001);
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= fpc_pkg::FPC_IDLE;
			memory_buffer_register_ff <= '0;
			address_register_ff <= '0;
		end else begin
			state_ff <= nxt_state;
			memory_buffer_register_ff <= nxt_buf;
			address_register_ff <= nxt_address_register;
		end
	end

	// instruction, exponent, flags
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			instruction_register_ff <= '0;
			exponent_register_a_ff <= '0;
			busy_ff <= 1'b0;
			cpu_inhibit_ff <= 1'b0;
			rri_ff <= 1'b0;
			ind_ff <= 1'b0;
			fetch_cyc_ff <= 1'b0;
			idx_ff <= 2'h0;
		end else begin
			if (state_ff == fpc_pkg::FPC_ADDR_RST) begin
				instruction_register_ff <= memory_buffer_register_ff[17:0];
			end
			if (detect) begin
				busy_ff <= 1'b1;
				cpu_inhibit_ff <= 1'b1;
				rri_ff <= 1'b1;
				fetch_cyc_ff <= 1'b1;
			end else if (nxt_state == fpc_pkg::FPC_IDLE) begin
				busy_ff <= 1'b0;
				cpu_inhibit_ff <= 1'b0;
				fetch_cyc_ff <= 1'b0;
			end
			if (nxt_state == fpc_pkg::FPC_SUBST) begin
				rri_ff <= 1'b0;
			end
			if (state_ff == fpc_pkg::FPC_LOAD_ADDR) begin
				ind_ff <= memory_buffer_register_ff[`FPC_IND_BIT];
				idx_ff <= 2'h0;
			end else if (state_ff == fpc_pkg::FPC_WORD) begin
				ind_ff <= 1'b0;
				if (!ind_ff) begin
					idx_ff <= 2'(idx_ff + 2'h1);
				end
			end
			if ((state_ff == fpc_pkg::FPC_IO_WAIT && io_free && !ind_ff) || nxt_state == fpc_pkg::FPC_ALIGN) begin
				fetch_cyc_ff <= 1'b0;
			end
			if (state_ff == fpc_pkg::FPC_WORD && !ind_ff && kind == fpc_pkg::FPC_K_EXPO) begin
				exponent_register_a_ff <= memory_buffer_register_ff[17:0];
			end
		end
	end

	// time states run while busy
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ts_ff <= 2'h0;
		end else if (!busy_ff) begin
			ts_ff <= 2'h0;
		end else begin
			ts_ff <= (ts_ff == `FPC_TS_LAST) ? 2'h1 : 2'(ts_ff + 2'h1);
		end
	end

	// data line drive, registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lines_out_ff <= '0;
			lines_oe_ff <= 1'b0;
		end else begin
			lines_out_ff <= (nxt_state == fpc_pkg::FPC_SUBST) ? `FPC_NOP_WORD : nxt_address_register;
			lines_oe_ff <= nxt_state == fpc_pkg::FPC_SUBST || nxt_state == fpc_pkg::FPC_MREQ;
		end
	end

	fpc_mant #(
		.MW(36)
	) u_mant (
		.pclk(pclk),
		.presetn(presetn),
		.clr_quot(clr_quot),
		.acc_to_quot(acc_to_quot),
		.acc_to_opb(acc_to_opb),
		.load_acc(load_acc),
		.acc_in(memory_buffer_register_ff),
		.acc(acc),
		.quot(quot),
		.opb(opb)
	);

	assign memory_data_lines_out = lines_out_ff;
	assign memory_data_lines_oe = lines_oe_ff;
	assign memory_request = in_mreq;
	assign memory_read_select = in_mreq;
	assign unit_release_data_ack = state_ff == fpc_pkg::FPC_ADDR_RDA || state_ff == fpc_pkg::FPC_MDACK;
	assign substitute_read_restart = in_subst;
	assign cpu_release_ack = state_ff == fpc_pkg::FPC_SUBST_ACK && memory_release;
	assign busy = busy_ff;
	assign cpu_activity_inhibit = cpu_inhibit_ff;
	assign read_restart_inhibit = rri_ff;
	assign priority_interrupt_disable = busy_ff;
	assign vectored_priority_interrupt_disable = busy_ff;
	assign characteristic_align_cycle = state_ff == fpc_pkg::FPC_ALIGN;

	// apb slave, no wait states
	wire setup = psel && !penable;
	wire wr_en = psel && penable && pwrite;
	wire a_ok = paddr[1:0] == 2'b00 && paddr <= `FPC_A_OPB;
	wire [31:0] status = {26'h0, ind_ff, fetch_cyc_ff, priority_interrupt_disable, rri_ff, cpu_inhibit_ff, busy_ff};
	logic [31:0] rd_mux;
	always_comb begin
		case (paddr)
			`FPC_A_CTRL: rd_mux = {31'h0, ctrl_en_ff};
			`FPC_A_STATUS: rd_mux = status;
			`FPC_A_INSTR: rd_mux = {14'h0, instruction_register_ff};
			`FPC_A_ADDR: rd_mux = {14'h0, address_register_ff};
			`FPC_A_EXPO: rd_mux = {14'h0, exponent_register_a_ff};
			`FPC_A_ACC_LO: rd_mux = acc[31:0];
			`FPC_A_ACC_HI: rd_mux = {28'h0, acc[35:32]};
			`FPC_A_QUOT: rd_mux = quot[31:0];
			`FPC_A_OPB: rd_mux = opb[31:0];
			default: rd_mux = 32'h0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_en_ff <= `FPC_CTRL_RST;
			prdata_ff <= '0;
		end else begin
			if (setup) begin
				prdata_ff <= rd_mux;
			end
			if (wr_en && paddr == `FPC_A_CTRL) begin
				ctrl_en_ff <= pwdata[0];
			end
		end
	end

	assign prdata = prdata_ff;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !a_ok;

	AST_DETECT: assert property (@(posedge pclk) disable iff (!presetn)
		(state_ff == fpc_pkg::FPC_IDLE && ctrl_en_ff && cpu_instruction_fetch_flag
		&& memory_data_lines_in[17:12] == 6'o71) |=> busy && read_restart_inhibit) else $error("opcode missed");
	AST_IR_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
		detect |=> ##1 instruction_register_ff == $past(memory_data_lines_in, 2))
		else $error("instruction register not loaded");
	AST_NOP: assert property (@(posedge pclk) disable iff (!presetn)
		substitute_read_restart |-> memory_data_lines_oe && memory_data_lines_out == 18'o710000
		&& !read_restart_inhibit) else $error("no-op substitution wrong");
	AST_CPU_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
		busy |-> cpu_activity_inhibit) else $error("cpu inhibit dropped while busy");
	AST_IO_WAIT: assert property (@(posedge pclk) disable iff (!presetn)
		(state_ff == fpc_pkg::FPC_IO_WAIT && io_request_pending) |=> !memory_request) else $error("request during io");
	AST_AR_INC: assert property (@(posedge pclk) disable iff (!presetn)
		(state_ff == fpc_pkg::FPC_WORD && !ind_ff) |=> address_register_ff == 18'($past(address_register_ff) + 18'h1))
		else $error("address not incremented");
	AST_SKIP: assert property (@(posedge pclk) disable iff (!presetn)
		(state_ff == fpc_pkg::FPC_IO_WAIT && io_free && !ind_ff && no_fetch) |=> characteristic_align_cycle)
		else $error("operand fetch not skipped");
	AST_RDA: assert property (@(posedge pclk) disable iff (!presetn)
		(unit_release_data_ack && release_acknowledge) |=> !unit_release_data_ack) else $error("ack not cleared");
	AST_REQ_DROP: assert property (@(posedge pclk) disable iff (!presetn)
		(memory_request && address_ack) |=> !memory_request && !memory_data_lines_oe) else $error("request held");
	AST_OE: assert property (@(posedge pclk) disable iff (!presetn)
		memory_data_lines_oe |-> busy) else $error("data lines driven while idle");
endmodule
`default_nettype wire

// *** fpc_host_model.sv ***
// host cpu and memory controller model facing the fetch sequencer
`timescale 1ns/1ps
`default_nettype none
module fpc_host_model (
	input wire logic pclk,
	input wire logic [17:0] memory_data_lines_out,
	input wire logic memory_data_lines_oe,
	input wire logic memory_request,
	input wire logic memory_read_select,
	input wire logic unit_release_data_ack,
	input wire logic substitute_read_restart,
	input wire logic cpu_release_ack,
	input wire logic fetch_start,
	input wire logic [17:0] fetch_word,
	input wire logic [17:0] addr_word,
	input wire logic [3:0] ack_delay,
	output logic [17:0] memory_data_lines_in,
	output logic cpu_instruction_fetch_flag,
	output logic read_restart,
	output logic address_ack,
	output logic release_acknowledge,
	output logic memory_release,
	output logic [7:0] req_count,
	output logic [17:0] last_addr,
	output logic [17:0] cpu_memory_input_register
);
	logic drv = 1'b0;
	logic [17:0] val = 18'h0;
	logic [17:0] held = 18'h0;
	initial begin
		{cpu_instruction_fetch_flag, read_restart, address_ack, release_acknowledge, memory_release} = 5'h00;
		req_count = 8'h00;
		last_addr = 18'h0;
		cpu_memory_input_register = 18'h0;
	end
	// released lines show the inverse of the last value
	assign memory_data_lines_in = memory_data_lines_oe ? memory_data_lines_out : (drv ? val : ~held);
	always @(posedge pclk) if (drv | memory_data_lines_oe) held <= memory_data_lines_in;
	task automatic give(input logic [17:0] d);
		drv <= 1'b1;
		val <= d;
		read_restart <= 1'b1;
		do @(posedge pclk); while (!unit_release_data_ack);
		read_restart <= 1'b0;
		drv <= 1'b0;
		release_acknowledge <= 1'b1;
		do @(posedge pclk); while (unit_release_data_ack);
		release_acknowledge <= 1'b0;
	endtask
	always begin
		@(posedge pclk);
		if (fetch_start) begin
			cpu_instruction_fetch_flag <= 1'b1;
			drv <= 1'b1;
			val <= fetch_word;
			@(posedge pclk);
			cpu_instruction_fetch_flag <= 1'b0;
			drv <= 1'b0;
			// cpu reads the next word, memory returns the operand address
			if (fetch_word[17:12] == 6'o71) begin
				repeat (ack_delay + 2) @(posedge pclk);
				give(addr_word);
			end
		end else if (memory_request) begin
			repeat (ack_delay) @(posedge pclk);
			address_ack <= 1'b1;
			last_addr <= memory_data_lines_out;
			req_count <= req_count + {7'h00, memory_read_select};
			do @(posedge pclk); while (memory_request);
			address_ack <= 1'b0;
			repeat (ack_delay + 1) @(posedge pclk);
			give(last_addr ^ 18'o401000);
		end
	end
	always begin
		@(posedge pclk);
		if (substitute_read_restart) begin
			cpu_memory_input_register <= memory_data_lines_in;
			memory_release <= 1'b1;
			do @(posedge pclk); while (!cpu_release_ack);
			memory_release <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// *** float_coproc_fetch_operand_seq_bench.sv ***
// self-checking bench for the coprocessor fetch sequencer
`timescale 1ns/1ps
`default_nettype none
`include "fpc_regs.svh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin failures++; $display("[ERR] %s expected %h seen %h", n, e, g); end end
module float_coproc_fetch_operand_seq_bench;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, memory_data_lines_oe, cpu_instruction_fetch_flag, read_restart, address_ack;
	logic release_acknowledge, memory_release, memory_request, memory_read_select, unit_release_data_ack;
	logic substitute_read_restart, cpu_release_ack, busy, cpu_activity_inhibit, read_restart_inhibit;
	logic priority_interrupt_disable, vectored_priority_interrupt_disable, characteristic_align_cycle;
	logic io_request_pending = 1'b0, align_done = 1'b0, fetch_start = 1'b0;
	logic [17:0] memory_data_lines_in, memory_data_lines_out, last_addr, cpu_memory_input_register;
	logic [17:0] fetch_word = 18'h0, addr_word = 18'h0;
	logic [3:0] ack_delay = 4'h0;
	logic [7:0] req_count;
	int failures = 0, total_checks = 0;
	always #10 pclk = ~pclk;
	fpc_seq uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.memory_data_lines_in, .memory_data_lines_out, .memory_data_lines_oe, .cpu_instruction_fetch_flag,
		.read_restart, .address_ack, .release_acknowledge, .memory_release, .io_request_pending, .align_done,
		.memory_request, .memory_read_select, .unit_release_data_ack, .substitute_read_restart, .cpu_release_ack,
		.busy, .cpu_activity_inhibit, .read_restart_inhibit, .priority_interrupt_disable,
		.vectored_priority_interrupt_disable, .characteristic_align_cycle);
	fpc_host_model host (.pclk, .memory_data_lines_out, .memory_data_lines_oe, .memory_request, .memory_read_select,
		.unit_release_data_ack, .substitute_read_restart, .cpu_release_ack, .fetch_start, .fetch_word,
		.addr_word, .ack_delay, .memory_data_lines_in, .cpu_instruction_fetch_flag, .read_restart,
		.address_ack, .release_acknowledge, .memory_release, .req_count, .last_addr, .cpu_memory_input_register);
	task automatic end_sim;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	function automatic logic [17:0] op(input logic nf, input logic [1:0] fm, input logic [4:0] fn);
		return {`FPC_OPC_VAL, 4'h0, nf, fm, fn};
	endfunction
	task automatic acc_chk(input logic [35:0] e);
		apb(1'b0, `FPC_A_ACC_LO, 32'h0);
		`CHK("acc_lo", e[31:0], rd)
		apb(1'b0, `FPC_A_ACC_HI, 32'h0);
		`CHK("acc_hi", e[35:32], rd[3:0])
	endtask
	task automatic run(input logic [17:0] w, input logic [17:0] a, input logic [7:0] nreq, input logic hold);
		int n;
		logic [7:0] c0;
		c0 = req_count;
		n = 0;
		fetch_word <= w;
		addr_word <= a;
		fetch_start <= 1'b1;
		io_request_pending <= hold;
		@(posedge pclk);
		fetch_start <= 1'b0;
		while (busy !== 1'b1 && n < 8) begin
			@(posedge pclk);
			n++;
		end
		`CHK("busy", 1'b1, busy)
		`CHK("rri", 1'b1, read_restart_inhibit)
		`CHK("int_off", 2'b11, {priority_interrupt_disable, vectored_priority_interrupt_disable})
		while (substitute_read_restart !== 1'b1 && n < 200) begin
			@(posedge pclk);
			n++;
		end
		while (substitute_read_restart === 1'b1 && n < 200) begin
			@(posedge pclk);
			n++;
		end
		`CHK("nop", `FPC_NOP_WORD, cpu_memory_input_register)
		`CHK("rri_clr", 1'b0, read_restart_inhibit)
		`CHK("cpu_inh", 1'b1, cpu_activity_inhibit)
		if (hold) begin
			repeat (20) @(posedge pclk);
			`CHK("io_wait", {c0, 2'b00}, {req_count, memory_request, characteristic_align_cycle})
			io_request_pending <= 1'b0;
		end
		while (characteristic_align_cycle !== 1'b1 && n < 600) begin
			@(posedge pclk);
			n++;
		end
		`CHK("align", 1'b1, characteristic_align_cycle)
		`CHK("reqs", nreq, req_count - c0)
		`CHK("lines_oe", 1'b0, memory_data_lines_oe)
		align_done <= 1'b1;
		@(posedge pclk);
		align_done <= 1'b0;
		repeat (3) @(posedge pclk);
		`CHK("done", 3'b000, {busy, cpu_activity_inhibit, priority_interrupt_disable})
		apb(1'b0, `FPC_A_INSTR, 32'h0);
		`CHK("instr", w, rd[17:0])
	endtask
	task automatic t_regs;
		apb(1'b0, `FPC_A_CTRL, 32'h0);
		`CHK("ctrl", 32'h0000_0001, rd)
		apb(1'b1, `FPC_A_CTRL, 32'h0000_0000);
		apb(1'b0, `FPC_A_CTRL, 32'h0);
		`CHK("ctrl_off", 32'h0000_0000, rd)
		apb(1'b1, `FPC_A_CTRL, 32'h0000_0001);
		apb(1'b1, `FPC_A_STATUS, 32'h0000_00FF);
		apb(1'b0, `FPC_A_STATUS, 32'h0);
		`CHK("status", 32'h0000_0000, rd)
		apb(1'b0, 8'h24, 32'h0);
		`CHK("unmapped", 33'h1_0000_0000, {err, rd})
		fetch_word <= 18'o700000;
		fetch_start <= 1'b1;
		@(posedge pclk);
		fetch_start <= 1'b0;
		repeat (6) @(posedge pclk);
		`CHK("no_detect", 1'b0, busy)
		$display("test regs done");
	endtask
	task automatic t_dfloat;
		run(op(1'b0, 2'b11, `FPC_FN_ADD), 18'o000200, 8'h03, 1'b0);
		`CHK("last_addr", 18'o000202, last_addr)
		apb(1'b0, `FPC_A_ADDR, 32'h0);
		`CHK("addr_reg", 18'o000203, rd[17:0])
		apb(1'b0, `FPC_A_EXPO, 32'h0);
		`CHK("expo", 18'o401200, rd[17:0])
		acc_chk({18'o401201, 18'o401202});
		$display("test double float done");
	endtask
	task automatic t_quot;
		run(op(1'b1, 2'b11, `FPC_FN_RDIV), 18'o0, 8'h00, 1'b0);
		apb(1'b0, `FPC_A_QUOT, 32'h0);
		`CHK("quot_rdiv", 32'h0A06_0282, rd)
		acc_chk({18'o401201, 18'o401202});
		run(op(1'b1, 2'b11, `FPC_FN_RSUB), 18'o0, 8'h00, 1'b0);
		apb(1'b0, `FPC_A_OPB, 32'h0);
		`CHK("opb_rsub", 32'h0A06_0282, rd)
		run(op(1'b1, 2'b11, `FPC_FN_SUB), 18'o0, 8'h00, 1'b0);
		apb(1'b0, `FPC_A_QUOT, 32'h0);
		`CHK("quot_sub", 32'h0000_0000, rd)
		$display("test quotient done");
	endtask
	task automatic t_formats;
		ack_delay <= 4'h3;
		run(op(1'b0, 2'b00, `FPC_FN_FIX), 18'o000100, 8'h01, 1'b1);
		acc_chk({18'o777777, 18'o401100});
		run(op(1'b0, 2'b10, `FPC_FN_ADD), 18'o000300, 8'h02, 1'b0);
		acc_chk({18'o401300, 18'o401301});
		run(op(1'b0, 2'b01, `FPC_FN_ADD), 18'o400500, 8'h03, 1'b0);
		`CHK("ind_last", 18'o001501, last_addr)
		apb(1'b0, `FPC_A_ADDR, 32'h0);
		`CHK("ind_addr", 18'o001502, rd[17:0])
		$display("test formats done");
	endtask
	initial begin
		repeat (50000) @(posedge pclk);
		failures++;
		end_sim;
	end
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs;
		t_dfloat;
		t_quot;
		t_formats;
		end_sim;
	end
endmodule
`default_nettype wire
